// ==== pkg/supervisor_pkg.sv ====
package supervisor_pkg;
    // ==================================================
    // types
    typedef logic [31:0] word_t;
    typedef logic [31:0] cnt_t;
    typedef logic [7:0] addr_t;
    typedef enum logic {WD_RUN, WD_PULSE} wdt_state_t;

    // ==================================================
    // timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned T_WDT_SHORT_MS = 100;
    localparam int unsigned T_WDT_LONG_MS = 1600;
    localparam int unsigned T_RST_PULSE_MS = 50;
    localparam int unsigned WDT_SHORT_CYC = T_WDT_SHORT_MS * CYC_PER_MS;
    localparam int unsigned WDT_LONG_CYC = T_WDT_LONG_MS * CYC_PER_MS;
    localparam int unsigned RST_PULSE_CYC = T_RST_PULSE_MS * CYC_PER_MS;
    localparam cnt_t EXT_WDT_NORMAL_CLKS = 32'h0000_0400;
    localparam cnt_t EXT_WDT_AFTER_CLKS = 32'h0000_1000;
    localparam cnt_t EXT_RST_PULSE_CLKS = 32'h0000_0200;
    localparam cnt_t CNT_ONE = 32'h0000_0001;
    localparam cnt_t CNT_ZERO = 32'h0000_0000;

    // ==================================================
    // register map
    localparam addr_t ADDR_CTRL = 8'h00;
    localparam addr_t ADDR_STATUS = 8'h04;
    localparam addr_t ADDR_MASK = 8'h08;
    localparam addr_t ADDR_STATE = 8'h0C;
    localparam int CTRL_WDT_EN = 0;
    localparam logic CTRL_WDT_EN_RST = 1'h1;
    localparam int EVT_WDT = 0;
    localparam int EVT_BACKUP = 1;
    localparam int EVT_PFAIL = 2;
    localparam int EVT_W = 3;
    localparam int STATE_W = 7;
    localparam word_t WORD_ZERO = 32'h0000_0000;

    function automatic logic addr_hit(input addr_t a, input addr_t off);
        return a == off;
    endfunction
endpackage

// ==== pkg/timebase_if.sv ====
`timescale 1ns/1ps
interface timebase_if;
    logic tick;
    logic ext_mode;
    supervisor_pkg::cnt_t normal_limit;
    supervisor_pkg::cnt_t after_limit;
    supervisor_pkg::cnt_t pulse_limit;
    modport source(output tick, ext_mode, normal_limit, after_limit, pulse_limit);
    modport sink(input tick, ext_mode, normal_limit, after_limit, pulse_limit);
endinterface

// ==== rtl/timebase_sel.sv ====
`timescale 1ns/1ps
module timebase_sel #(
    parameter supervisor_pkg::cnt_t SHORT_CYC = 32'h0000_0001,
    parameter supervisor_pkg::cnt_t LONG_CYC = 32'h0000_0001,
    parameter supervisor_pkg::cnt_t PULSE_CYC = 32'h0000_0001
) (
    input logic pclk,
    input logic presetn,
    input logic timebase_select,
    input logic timebase_input,
    input logic freeze,
    timebase_if.source tb
);
    import supervisor_pkg::*;
    logic sel_reg;
    logic lvl_reg;
    logic in_prev_reg;

    // config is frozen while in backup, so the pins are ignored there
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= 1'h1;
            lvl_reg <= 1'h1;
        end else if (!freeze) begin
            sel_reg <= timebase_select;
            lvl_reg <= timebase_input;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_prev_reg <= 1'h0;
        end else begin
            in_prev_reg <= timebase_input;
        end
    end

    // external mode counts rising edges of the timing input
    assign tb.ext_mode = !sel_reg;
    assign tb.tick = sel_reg ? 1'h1 : (timebase_input && !in_prev_reg);
    assign tb.normal_limit = !sel_reg ? EXT_WDT_NORMAL_CLKS : (lvl_reg ? LONG_CYC : SHORT_CYC);
    assign tb.after_limit = !sel_reg ? EXT_WDT_AFTER_CLKS : LONG_CYC;
    assign tb.pulse_limit = !sel_reg ? EXT_RST_PULSE_CLKS : PULSE_CYC;
endmodule // timebase_sel

// ==== rtl/watchdog_core.sv ====
`timescale 1ns/1ps
module watchdog_core (
    input logic pclk,
    input logic presetn,
    timebase_if.sink tb,
    input logic kick,
    input logic kick_driven,
    input logic wdt_enable,
    input logic hold,
    output logic reset_active,
    output logic timeout_n,
    output logic timeout_evt
);
    import supervisor_pkg::*;
    wdt_state_t state_reg;
    cnt_t cnt_reg;
    cnt_t limit;
    logic after_reset_reg;
    logic kick_prev_reg;
    logic timeout_n_reg;
    logic evt_reg;
    logic toggled;
    logic active;
    logic expire;

    // a floating kick input means supervision is off
    assign toggled = kick_driven && (kick != kick_prev_reg);
    assign active = kick_driven && wdt_enable;
    assign limit = after_reset_reg ? tb.after_limit : tb.normal_limit;
    assign expire = (state_reg == WD_RUN) && !toggled && active && tb.tick && (cnt_reg >= limit - CNT_ONE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kick_prev_reg <= 1'h0;
        end else begin
            kick_prev_reg <= kick;
        end
    end

    // ==================================================
    // period and reset pulse sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= WD_PULSE;
            cnt_reg <= CNT_ZERO;
            after_reset_reg <= 1'h1;
            evt_reg <= 1'h0;
        end else begin
            evt_reg <= 1'h0;
            if (hold) begin
                state_reg <= WD_PULSE;
                cnt_reg <= CNT_ZERO;
                after_reset_reg <= 1'h1;
            end else begin
                unique case (state_reg)
                    WD_RUN: begin
                        if (toggled) begin
                            cnt_reg <= CNT_ZERO;
                            after_reset_reg <= 1'h0;
                        end else if (!active) begin
                            cnt_reg <= CNT_ZERO;
                        end else if (expire) begin
                            state_reg <= WD_PULSE;
                            cnt_reg <= CNT_ZERO;
                            after_reset_reg <= 1'h1;
                            evt_reg <= 1'h1;
                        end else if (tb.tick) begin
                            cnt_reg <= cnt_reg + CNT_ONE;
                        end
                    end
                    WD_PULSE: begin
                        if (tb.tick && (cnt_reg >= tb.pulse_limit - CNT_ONE)) begin
                            state_reg <= WD_RUN;
                            cnt_reg <= CNT_ZERO;
                        end else if (tb.tick) begin
                            cnt_reg <= cnt_reg + CNT_ONE;
                        end
                    end
                endcase
            end
        end
    end

    // timeout flag stays low until the next kick edge or until hold is raised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_n_reg <= 1'h1;
        end else if (hold || toggled) begin
            timeout_n_reg <= 1'h1;
        end else if (expire) begin
            timeout_n_reg <= 1'h0;
        end
    end

    assign reset_active = (state_reg == WD_PULSE);
    assign timeout_n = timeout_n_reg;
    assign timeout_evt = evt_reg;
endmodule // watchdog_core

// ==== rtl/supervisor_top.sv ====
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module supervisor_top #(
    parameter supervisor_pkg::cnt_t WDT_SHORT_CYCLES = supervisor_pkg::WDT_SHORT_CYC,
    parameter supervisor_pkg::cnt_t WDT_LONG_CYCLES = supervisor_pkg::WDT_LONG_CYC,
    parameter supervisor_pkg::cnt_t RST_PULSE_CYCLES = supervisor_pkg::RST_PULSE_CYC
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input supervisor_pkg::addr_t paddr,
    input supervisor_pkg::word_t pwdata,
    output supervisor_pkg::word_t prdata,
    output logic pready,
    output logic pslverr,
    input logic backup_mode,
    input logic supply_low,
    input logic power_fail_in,
    input logic ce_in_n,
    input logic watchdog_kick_in,
    input logic watchdog_kick_driven,
    input logic timebase_select,
    input logic timebase_input,
    output logic reset_n_out,
    output logic reset_out,
    output logic low_supply_n,
    output logic backup_active_flag,
    output logic watchdog_timeout_out,
    output logic power_fail_out,
    output logic ce_out_n,
    output logic irq
);
    import supervisor_pkg::*;

    // ==================================================
    // declarations
    logic ctrl_wdt_en_reg;
    logic [EVT_W-1:0] status_reg;
    logic [EVT_W-1:0] mask_reg;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    word_t prdata_reg;
    word_t rd_data;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic backup_prev_reg;
    logic setup;
    logic access;
    logic mapped;
    logic rd_clear;
    logic wd_reset_active;
    logic wd_timeout_n;
    logic wd_timeout_evt;
    logic hold;
    logic reset_n_reg;
    logic reset_reg;
    logic low_supply_n_reg;
    logic backup_flag_reg;
    logic tmo_reg;
    logic pf_reg;
    logic ce_out_n_reg;
    logic pf_next;
    logic [STATE_W-1:0] state_bits;

    timebase_if tb_bus();

    // ==================================================
    // timebase and watchdog
    timebase_sel #(
        .SHORT_CYC(WDT_SHORT_CYCLES),
        .LONG_CYC(WDT_LONG_CYCLES),
        .PULSE_CYC(RST_PULSE_CYCLES)
    ) u_timebase (
        .pclk(pclk),
        .presetn(presetn),
        .timebase_select(timebase_select),
        .timebase_input(timebase_input),
        .freeze(backup_mode),
        .tb(tb_bus.source)
    );

    // backup and low supply both hold the watchdog in reset
    assign hold = backup_mode || supply_low;

    watchdog_core u_watchdog (
        .pclk(pclk),
        .presetn(presetn),
        .tb(tb_bus.sink),
        .kick(watchdog_kick_in),
        .kick_driven(watchdog_kick_driven),
        .wdt_enable(ctrl_wdt_en_reg),
        .hold(hold),
        .reset_active(wd_reset_active),
        .timeout_n(wd_timeout_n),
        .timeout_evt(wd_timeout_evt)
    );

    // ==================================================
    // pin outputs
    // power-fail comparison is switched off in backup to save battery
    assign pf_next = backup_mode ? 1'h0 : power_fail_in;

    // decided from the backup input itself, not from watchdog state,
    // so forcing lands at the very first edge that sees backup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_n_reg <= 1'h0;
            reset_reg <= 1'h1;
            low_supply_n_reg <= 1'h0;
            backup_flag_reg <= 1'h0;
            tmo_reg <= 1'h1;
            pf_reg <= 1'h0;
            ce_out_n_reg <= 1'h1;
        end else begin
            reset_n_reg <= !(hold || wd_reset_active);
            reset_reg <= hold || wd_reset_active;
            low_supply_n_reg <= !hold;
            backup_flag_reg <= backup_mode;
            tmo_reg <= backup_mode ? 1'h1 : wd_timeout_n;
            pf_reg <= pf_next;
            ce_out_n_reg <= hold ? 1'h1 : ce_in_n;
        end
    end

    assign reset_n_out = reset_n_reg;
    assign reset_out = reset_reg;
    assign low_supply_n = low_supply_n_reg;
    assign backup_active_flag = backup_flag_reg;
    assign watchdog_timeout_out = tmo_reg;
    assign power_fail_out = pf_reg;
    assign ce_out_n = ce_out_n_reg;

    // ==================================================
    // apb slave
    // one wait-free access: data is prepared during setup
    assign setup = psel && !penable;
    assign access = psel && penable && pready_reg;
    assign mapped = addr_hit(paddr, ADDR_CTRL) || addr_hit(paddr, ADDR_STATUS) ||
        addr_hit(paddr, ADDR_MASK) || addr_hit(paddr, ADDR_STATE);

    assign state_bits = {tb_bus.ext_mode, low_supply_n_reg, ce_out_n_reg, pf_reg,
        tmo_reg, reset_n_reg, backup_flag_reg};

    always_comb begin
        rd_data = WORD_ZERO;
        if (addr_hit(paddr, ADDR_CTRL)) begin
            rd_data[CTRL_WDT_EN] = ctrl_wdt_en_reg;
        end else if (addr_hit(paddr, ADDR_STATUS)) begin
            rd_data[EVT_W-1:0] = status_reg;
        end else if (addr_hit(paddr, ADDR_MASK)) begin
            rd_data[EVT_W-1:0] = mask_reg;
        end else if (addr_hit(paddr, ADDR_STATE)) begin
            rd_data[STATE_W-1:0] = state_bits;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'h0;
            pslverr_reg <= 1'h0;
            prdata_reg <= WORD_ZERO;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            prdata_reg <= (setup && !pwrite) ? rd_data : WORD_ZERO;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // disabling here is possible but lengthening the period is safer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_wdt_en_reg <= CTRL_WDT_EN_RST;
            mask_reg <= '0;
        end else if (access && pwrite) begin
            if (addr_hit(paddr, ADDR_CTRL)) begin
                ctrl_wdt_en_reg <= pwdata[CTRL_WDT_EN];
            end
            if (addr_hit(paddr, ADDR_MASK)) begin
                mask_reg <= pwdata[EVT_W-1:0];
            end
        end
    end

    // ==================================================
    // interrupts
    // only bits that were actually returned are cleared, and a new
    // event in the clearing cycle still sets its bit
    assign rd_clear = access && !pwrite && addr_hit(paddr, ADDR_STATUS);
    assign evt_clr = rd_clear ? prdata_reg[EVT_W-1:0] : '0;
    assign evt_set = {
        pf_reg && !pf_next && !backup_mode,
        backup_mode && !backup_prev_reg,
        wd_timeout_evt
    };

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= '0;
            backup_prev_reg <= 1'h0;
            irq_reg <= 1'h0;
        end else begin
            status_reg <= (status_reg & ~evt_clr) | evt_set;
            backup_prev_reg <= backup_mode;
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    assign irq = irq_reg;

    // ==================================================
    // checks
    AST_BACKUP_RESET_N: assert property (
        @(posedge pclk) disable iff (!presetn)
        backup_mode |=> !reset_n_out
    ) else $error("reset_n not low in backup");

    AST_BACKUP_FLAGS: assert property (
        @(posedge pclk) disable iff (!presetn)
        backup_mode |=> (!low_supply_n && backup_active_flag && watchdog_timeout_out)
    ) else $error("backup flags not forced");

    AST_BACKUP_RESET_HI: assert property (
        @(posedge pclk) disable iff (!presetn)
        backup_mode |=> reset_out
    ) else $error("active high reset not high in backup");

    AST_BACKUP_CE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (backup_mode && !ce_in_n) |=> ce_out_n
    ) else $error("chip enable passed in backup");

    AST_BACKUP_PF_IN: assert property (
        @(posedge pclk) disable iff (!presetn)
        (backup_mode && power_fail_in) [*2] |=> !power_fail_out
    ) else $error("power fail input leaked in backup");

    AST_FLOAT_NO_TIMEOUT: assert property (
        @(posedge pclk) disable iff (!presetn)
        !watchdog_kick_driven |=> !wd_timeout_evt
    ) else $error("timeout while kick input floating");

    AST_EXT_TIMEBASE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!backup_mode && !timebase_select) |=>
            (tb_bus.normal_limit == EXT_WDT_NORMAL_CLKS && tb_bus.ext_mode)
    ) else $error("external timebase not chosen");

    AST_INT_SHORT: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!backup_mode && timebase_select && !timebase_input) |=>
            (tb_bus.normal_limit == WDT_SHORT_CYCLES)
    ) else $error("short internal period not chosen");

    AST_INT_LONG: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!backup_mode && timebase_select && timebase_input) |=>
            (tb_bus.normal_limit == WDT_LONG_CYCLES)
    ) else $error("long internal period not chosen");

    AST_BACKUP_PF_OUT: assert property (
        @(posedge pclk) disable iff (!presetn)
        backup_mode |=> !power_fail_out
    ) else $error("power fail output not low in backup");

    AST_TIMEOUT_RESET: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wd_timeout_evt && !hold) |=> (!reset_n_out && reset_out && !watchdog_timeout_out)
    ) else $error("timeout did not start reset pulse");

    AST_FORCE_FIRST_EDGE: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(backup_mode) |=> (ce_out_n && !power_fail_out && !reset_n_out)
    ) else $error("forcing late after backup entry");

    AST_IRQ_LEVEL: assert property (
        @(posedge pclk) disable iff (!presetn)
        (|(status_reg & mask_reg)) |=> irq
    ) else $error("irq missing for unmasked status");

    AST_PF_FOLLOW: assert property (
        @(posedge pclk) disable iff (!presetn)
        !backup_mode |=> (power_fail_out == $past(power_fail_in))
    ) else $error("power fail output not following input");

    AST_CE_FOLLOW: assert property (
        @(posedge pclk) disable iff (!presetn)
        !hold |=> (ce_out_n == $past(ce_in_n))
    ) else $error("chip enable not following input");

    AST_CONFIG_FROZEN: assert property (
        @(posedge pclk) disable iff (!presetn)
        backup_mode |=> ($stable(tb_bus.ext_mode) && $stable(tb_bus.normal_limit))
    ) else $error("timebase config changed in backup");

    AST_HOLD_NO_EVT: assert property (
        @(posedge pclk) disable iff (!presetn)
        hold |=> !wd_timeout_evt
    ) else $error("timeout while held");

    AST_DISABLED_NO_EVT: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ctrl_wdt_en_reg |=> !wd_timeout_evt
    ) else $error("timeout while disabled");

    AST_PREADY_ONE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready
    ) else $error("pready missing after setup");

    AST_PREADY_PULSE: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready
    ) else $error("pready longer than one cycle");

    AST_SLVERR: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !mapped) |=> pslverr
    ) else $error("no error for unmapped address");

    AST_STATUS_WDT: assert property (
        @(posedge pclk) disable iff (!presetn)
        wd_timeout_evt |=> status_reg[EVT_WDT]
    ) else $error("timeout status not set");

    AST_STATUS_BACKUP: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(backup_mode) |=> status_reg[EVT_BACKUP]
    ) else $error("backup entry status not set");

    AST_IRQ_CLEAR: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(|(status_reg & mask_reg)) |=> !irq
    ) else $error("irq high without unmasked status");
endmodule // supervisor_top

// ==== test/cpu_partner.sv ====
`timescale 1ns/1ps
// ==================================================
// processor side: toggles the kick line or floats it
module cpu_partner (
    input wire logic pclk,
    input wire logic drive_en,
    input wire logic kick_on,
    output logic watchdog_kick_in,
    output logic watchdog_kick_driven
);
    logic level_reg;
    logic noise_reg;
    int gap_reg;
    initial begin
        level_reg = 1'b0;
        noise_reg = 1'b0;
        gap_reg = 0;
    end
    // one kick edge every fifth cycle, well inside the shortest period
    always @(posedge pclk) begin
        noise_reg <= ~noise_reg;
        gap_reg <= (gap_reg == 4) ? 0 : gap_reg + 1;
        if (drive_en && kick_on && gap_reg == 4) begin
            level_reg <= ~level_reg;
        end
    end
    // a floated line keeps moving so that a stale level cannot look valid
    assign watchdog_kick_driven = drive_en;
    assign watchdog_kick_in = drive_en ? level_reg : noise_reg;
endmodule // cpu_partner

// ==== test/backup_mode_output_forcing_tb_top.sv ====
`timescale 1ns/1ps
module backup_mode_output_forcing_tb_top;
    import supervisor_pkg::*;
    // ==================================================
    // setup
    localparam int SHORT = 20;
    localparam int LONG = 40;
    localparam int PULSE = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    addr_t paddr;
    word_t pwdata, prdata, rd;
    logic backup_mode, supply_low, power_fail_in, ce_in_n, timebase_select, timebase_input;
    logic kick, kick_driven, drive_en, kick_on, irq;
    logic reset_n_out, reset_out, low_supply_n, backup_active_flag;
    logic watchdog_timeout_out, power_fail_out, ce_out_n;
    int miscompares, compares, n;

    supervisor_top #(
        .WDT_SHORT_CYCLES(cnt_t'(SHORT)),
        .WDT_LONG_CYCLES(cnt_t'(LONG)),
        .RST_PULSE_CYCLES(cnt_t'(PULSE))
    ) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .backup_mode(backup_mode), .supply_low(supply_low), .power_fail_in(power_fail_in),
        .ce_in_n(ce_in_n), .watchdog_kick_in(kick), .watchdog_kick_driven(kick_driven),
        .timebase_select(timebase_select), .timebase_input(timebase_input),
        .reset_n_out(reset_n_out), .reset_out(reset_out), .low_supply_n(low_supply_n),
        .backup_active_flag(backup_active_flag), .watchdog_timeout_out(watchdog_timeout_out),
        .power_fail_out(power_fail_out), .ce_out_n(ce_out_n), .irq(irq)
    );
    cpu_partner cpu (
        .pclk(pclk), .drive_en(drive_en), .kick_on(kick_on),
        .watchdog_kick_in(kick), .watchdog_kick_driven(kick_driven)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ==================================================
    // helpers
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask

    task automatic chk(input string what, input word_t exp, input word_t got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // values read at an edge are the settled ones from the edge before
    task automatic wait_lvl(input logic v, input int lim, output int c);
        c = 0;
        while (reset_n_out !== v && c < lim) begin
            @(posedge pclk);
            c++;
        end
    endtask

    task automatic apb(input logic w, input addr_t a, input word_t d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, pready);
    endtask

    task automatic end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==================================================
    // scenarios
    task automatic t_float_regs();
        tick(3 * LONG);
        chk("float reset_n", 32'h1, reset_n_out);
        apb(1'b0, ADDR_CTRL, WORD_ZERO);
        chk("ctrl", 32'h1, rd & 32'h1);
        apb(1'b0, ADDR_MASK, WORD_ZERO);
        chk("mask", 32'h0, rd);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        chk("slverr", 32'h1, err);
        apb(1'b0, 8'h10, WORD_ZERO);
        chk("unmapped", 32'h0, rd);
    endtask

    task automatic t_timeout(input int period);
        kick_on <= 1'b1;
        tick(60);
        chk("kicked reset_n", 32'h1, reset_n_out);
        kick_on <= 1'b0;
        wait_lvl(1'b0, 200, n);
        chk("period", 32'h1, n >= period - 6 && n <= period + 3);
        chk("reset_out", 32'h1, reset_out);
        wait_lvl(1'b1, 100, n);
        chk("pulse", 32'h1, n >= PULSE && n <= PULSE + 1);
        chk("timeout low", 32'h0, watchdog_timeout_out);
        kick_on <= 1'b1;
        tick(12);
        chk("timeout high", 32'h1, watchdog_timeout_out);
    endtask

    task automatic t_irq();
        chk("irq set", 32'h1, irq);
        apb(1'b1, ADDR_MASK, WORD_ZERO);
        tick(2);
        chk("irq masked", 32'h0, irq);
        apb(1'b0, ADDR_STATUS, WORD_ZERO);
        chk("status", 32'h1, rd & 32'h1);
        apb(1'b0, ADDR_STATUS, WORD_ZERO);
        chk("status clr", 32'h0, rd & 32'h1);
        apb(1'b1, ADDR_CTRL, WORD_ZERO);
        kick_on <= 1'b0;
        tick(3 * LONG);
        apb(1'b0, ADDR_STATUS, WORD_ZERO);
        chk("wdt off", 32'h0, rd & 32'h1);
        kick_on <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    endtask

    // stretching the period with an external time base beats floating the kick line
    task automatic t_external();
        timebase_select <= 1'b0;
        kick_on <= 1'b0;
        tick(3 * LONG);
        chk("ext idle", 32'h1, reset_n_out);
        n = 0;
        while (reset_n_out !== 1'b0 && n < 12000) begin
            @(posedge pclk);
            timebase_input <= ~timebase_input;
            n++;
        end
        chk("ext period", 32'h1, n >= 2 * int'(EXT_WDT_NORMAL_CLKS) - 12
            && n <= 2 * int'(EXT_WDT_AFTER_CLKS) + 12);
        timebase_select <= 1'b1;
        timebase_input <= 1'b0;
        kick_on <= 1'b1;
        wait_lvl(1'b1, 2000, n);
    endtask

    task automatic t_pins();
        power_fail_in <= 1'b0;
        ce_in_n <= 1'b0;
        tick(2);
        chk("pf out low", 32'h0, power_fail_out);
        chk("ce follows", 32'h0, ce_out_n);
        supply_low <= 1'b1;
        power_fail_in <= 1'b1;
        tick(2);
        chk("low supply", 32'h0, low_supply_n);
        chk("ce gated", 32'h1, ce_out_n);
        chk("pf out high", 32'h1, power_fail_out);
        supply_low <= 1'b0;
        tick(2);
        chk("ce back", 32'h0, ce_out_n);
    endtask

    task automatic t_backup();
        backup_mode <= 1'b1;
        tick(2);
        repeat (10) begin
            chk("forced", 32'h2D, {reset_n_out, reset_out, low_supply_n, backup_active_flag,
                watchdog_timeout_out, power_fail_out, ce_out_n});
            power_fail_in <= ~power_fail_in;
            ce_in_n <= ~ce_in_n;
            timebase_select <= ~timebase_select;
            timebase_input <= ~timebase_input;
            @(posedge pclk);
        end
        apb(1'b0, ADDR_STATE, WORD_ZERO);
        chk("state backup", 32'h1, rd & 32'h1);
        power_fail_in <= 1'b1;
        ce_in_n <= 1'b0;
        timebase_select <= 1'b1;
        timebase_input <= 1'b0;
        backup_mode <= 1'b0;
        wait_lvl(1'b1, 200, n);
        chk("pf after", 32'h1, power_fail_out);
        chk("ce after", 32'h0, ce_out_n);
        power_fail_in <= 1'b0;
        tick(2);
        apb(1'b0, ADDR_STATUS, WORD_ZERO);
        chk("status events", 32'h6, rd & 32'h6);
    endtask

    // ==================================================
    // main sequence and watchdog
    initial begin
        miscompares = 0;
        compares = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, backup_mode, supply_low, drive_en, kick_on} = '0;
        {power_fail_in, ce_in_n, timebase_select, timebase_input} = 4'h6;
        paddr = 8'h00;
        pwdata = WORD_ZERO;
        tick(16);
        presetn <= 1'b1;
        wait_lvl(1'b1, 100, n);
        t_float_regs();
        drive_en <= 1'b1;
        apb(1'b1, ADDR_MASK, 32'h0000_0001);
        t_timeout(SHORT);
        t_irq();
        timebase_input <= 1'b1;
        t_timeout(LONG);
        timebase_input <= 1'b0;
        t_external();
        t_pins();
        t_backup();
        end_of_test();
    end

    initial begin
        #800000;
        miscompares++;
        end_of_test();
    end
endmodule // backup_mode_output_forcing_tb_top
